/* core/ldg_irq_dma_gate.sv */
// per logical device irq/dma routing, gating and base address decode
// assumes unit registers and requests come from logic on i_mclk
`timescale 1ns/10ps
`default_nettype none

module ldg_irq_dma_gate (
  // clock and reset
  input  wire logic                             i_mclk,
  input  wire logic                             i_nrst,
  input  wire logic                             i_soft_rst,
  // configuration register port
  input  wire logic                             i_cfg_wr,
  input  wire logic [2:0]                       i_cfg_ld,
  input  wire logic [7:0]                       i_cfg_index,
  input  wire logic [7:0]                       i_cfg_wdata,
  output logic      [7:0]                       o_cfg_rdata,
  // global configuration
  input  wire logic                             i_device_numbering_select,
  input  wire logic [7:0]                       i_global_config_reg_24h,
  input  wire logic [ldg_pkg::NSLOT-1:0]        i_dev_active,
  // unit enable registers
  input  wire logic [7:0]                       i_floppy_digital_output_reg,
  input  wire logic                             i_floppy_powered_down,
  input  wire logic [7:0]                       i_parallel_control_reg,
  input  wire logic                             i_pp_ecp_mode,
  input  wire logic [7:0]                       i_ecp_ext_control_reg,
  input  wire logic [ldg_pkg::NSER-1:0][7:0]    i_uart_int_enable_reg,
  input  wire logic [ldg_pkg::NSER-1:0][7:0]    i_modem_control_reg,
  input  wire logic                             i_kbd_irq_enable,
  // unit requests
  input  wire logic [ldg_pkg::NSLOT-1:0]        i_dev_irq,
  input  wire logic [ldg_pkg::NDRQ_SRC-1:0]     i_dev_drq,
  // host side
  input  wire logic [15:0]                      i_io_addr,
  input  wire logic                             i_io_strobe,
  output logic      [ldg_pkg::NIRQ-1:0]         o_irq,
  output logic      [ldg_pkg::NDMA-1:0]         o_drq,
  output logic      [ldg_pkg::NSLOT-1:0]        o_dev_sel,
  output logic      [2:0]                       o_reg_off,
  output logic                                  o_pp_ext_sel
);
  import ldg_pkg::*;

  ldg_ldcfg_type          cfg      [NSLOT];
  ldg_ldcfg_type          next_cfg [NSLOT];
  logic [7:0]             next_cfg_rdata;
  logic [NIRQ-1:0]        next_irq;
  logic [NDMA-1:0]        next_drq;
  logic [NSLOT-1:0]       next_dev_sel;
  logic [2:0]             next_reg_off;
  logic                   next_pp_ext_sel;

  logic [NSLOT-1:0]       ld_hit;
  logic [NSLOT-1:0]       base_ok;
  logic [NSLOT-1:0]       addr_match;
  logic [NSLOT-1:0]       io_hit;
  logic [NSLOT-1:0]       irq_cond;
  logic [NSLOT-1:0]       irq_on;
  logic [NDRQ_SRC-1:0]    dma_cond;
  logic [NDRQ_SRC-1:0]    dma_on;
  logic [NSER-1:0]        ser_cond;
  logic                   qual_ok;
  logic                   pp_force_on;
  logic                   pp_epp_ok;
  logic                   pp_ext;
  logic [2:0]             pp_mode;
  logic [11:0]            io_a;
  logic [12:0]            pp_diff;

  assign io_a    = i_io_addr[11:0];
  assign qual_ok = !i_global_config_reg_24h[GLOBAL_CONFIG_REG_24H_QUAL16_BIT]
                   || (i_io_addr[15:12] == 4'h0);

  // per slot config select, base check and address window
  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    logic [11:0] b;
    assign b = cfg[s].base[11:0];
    assign ld_hit[s] = (i_cfg_ld == (i_device_numbering_select ?
                        LD_MAP1[s*3 +: 3] : LD_MAP0[s*3 +: 3]));
    if (s == SLOT_KBD) begin : g_kbd
      assign base_ok[s]    = 1'b1;
      assign addr_match[s] = (io_a == KBD_DATA) || (io_a == KBD_CMD);
    end else if (s == SLOT_PP) begin : g_pp
      assign base_ok[s]    = (b >= BASE_MIN) && (b <= BASE_MAX4)
                             && (b[1:0] == 2'h0);
      assign addr_match[s] = (io_a[11:2] == b[11:2])
                             || (pp_epp_ok && (io_a[11:3] == b[11:3]))
                             || pp_ext;
    end else begin : g_std
      assign base_ok[s]    = (b >= BASE_MIN) && (b <= BASE_MAX8)
                             && (b[2:0] == 3'h0);
      assign addr_match[s] = (io_a[11:3] == b[11:3]);
    end
    // out of range base or inactive device drops the access
    assign io_hit[s] = i_io_strobe && qual_ok && i_dev_active[s]
                       && base_ok[s] && addr_match[s];
    assign irq_on[s] = i_dev_irq[s] && irq_cond[s] && i_dev_active[s]
                       && base_ok[s] && (cfg[s].irq_sel != IRQ_SEL_NONE);
  end

  // extended parallel registers above the base
  assign pp_epp_ok = (cfg[SLOT_PP].base[2] == 1'b0);
  assign pp_diff   = {1'b0, io_a} - {1'b0, cfg[SLOT_PP].base[11:0]};
  assign pp_ext    = (pp_diff >= PP_EXT_LO) && (pp_diff <= PP_EXT_HI);

  // device own enable conditions
  assign pp_mode     = i_ecp_ext_control_reg[ECR_MODE_LSB +: 3];
  assign pp_force_on = (pp_mode == PMODE_FIFO) || (pp_mode == PMODE_ECP)
                       || (pp_mode == PMODE_TEST);
  assign irq_cond[SLOT_FDC] = i_floppy_digital_output_reg[DOR_DMA_BIT]
                              && !i_floppy_powered_down;
  assign irq_cond[SLOT_PP]  = i_pp_ecp_mode ?
      ((pp_force_on || i_parallel_control_reg[PCTL_PARALLEL_IRQ_ENABLE_BIT])
       && !i_ecp_ext_control_reg[ECR_SVC_BIT]) :
      i_parallel_control_reg[PCTL_PARALLEL_IRQ_ENABLE_BIT];
  for (genvar j = 0; j < NSER; j++) begin : g_ser
    assign ser_cond[j] = (|i_uart_int_enable_reg[j][IER_MSB:0])
                         && i_modem_control_reg[j][MCR_MODEM_AUX_OUTPUT_TWO_BIT];
  end
  assign irq_cond[SLOT_SA]  = ser_cond[0];
  assign irq_cond[SLOT_SB]  = ser_cond[1];
  assign irq_cond[SLOT_KBD] = i_kbd_irq_enable;

  assign dma_cond[SLOT_FDC] = irq_cond[SLOT_FDC];
  assign dma_cond[SLOT_PP]  = i_pp_ecp_mode
                              && i_ecp_ext_control_reg[ECR_DMA_BIT];
  for (genvar k = 0; k < NDRQ_SRC; k++) begin : g_dma
    assign dma_on[k] = i_dev_drq[k] && dma_cond[k] && i_dev_active[k]
                       && base_ok[k]
                       && (cfg[k].dma_sel >= DMA_CH_MIN)
                       && (cfg[k].dma_sel <= DMA_CH_MAX);
  end

  // configuration registers
  always_comb begin
    for (int s = 0; s < NSLOT; s++) begin
      next_cfg[s] = cfg[s];
      if (i_soft_rst) begin
        next_cfg[s] = ldg_cfg_rst(s);
      end else if (i_cfg_wr && ld_hit[s]) begin
        case (i_cfg_index)
          IDX_BASE_HI: begin
            if (s != SLOT_KBD) begin
              next_cfg[s].base[15:8] = i_cfg_wdata;
            end
          end
          IDX_BASE_LO: begin
            if (s != SLOT_KBD) begin
              next_cfg[s].base[7:0] = i_cfg_wdata;
            end
          end
          IDX_IRQ_SEL: begin
            next_cfg[s].irq_sel = i_cfg_wdata[3:0];
          end
          IDX_DMA_SEL: begin
            if (s < NDRQ_SRC) begin
              next_cfg[s].dma_sel = i_cfg_wdata[2:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // readback of the addressed logical device
  always_comb begin
    next_cfg_rdata = 8'h00;
    for (int s = 0; s < NSLOT; s++) begin
      if (ld_hit[s]) begin
        case (i_cfg_index)
          IDX_BASE_HI: begin
            if (s != SLOT_KBD) begin
              next_cfg_rdata = cfg[s].base[15:8];
            end
          end
          IDX_BASE_LO: begin
            if (s != SLOT_KBD) begin
              next_cfg_rdata = cfg[s].base[7:0];
            end
          end
          IDX_IRQ_SEL: begin
            next_cfg_rdata = {4'h0, cfg[s].irq_sel};
          end
          IDX_DMA_SEL: begin
            if (s < NDRQ_SRC) begin
              next_cfg_rdata = {5'h00, cfg[s].dma_sel};
            end
          end
          default: begin
            next_cfg_rdata = 8'h00;
          end
        endcase
      end
    end
  end

  // irq and dma routing onto the host lines
  always_comb begin
    next_irq = '0;
    next_drq = '0;
    for (int n = 1; n < NIRQ; n++) begin
      for (int s = 0; s < NSLOT; s++) begin
        if (irq_on[s] && (cfg[s].irq_sel == 4'(n))) begin
          next_irq[n] = 1'b1;
        end
      end
    end
    for (int c = 1; c < NDMA; c++) begin
      for (int k = 0; k < NDRQ_SRC; k++) begin
        if (dma_on[k] && (cfg[k].dma_sel == 3'(c))) begin
          next_drq[c] = 1'b1;
        end
      end
    end
  end

  // io decode; lowest slot wins on overlapping bases
  always_comb begin
    next_dev_sel    = '0;
    next_reg_off    = 3'h0;
    next_pp_ext_sel = 1'b0;
    for (int s = NSLOT - 1; s >= 0; s--) begin
      if (io_hit[s]) begin
        next_dev_sel    = '0;
        next_dev_sel[s] = 1'b1;
        next_reg_off    = (s == SLOT_PP && pp_ext) ? pp_diff[2:0] : io_a[2:0];
        next_pp_ext_sel = (s == SLOT_PP) && pp_ext;
      end
    end
  end

  // configuration state; a soft reset beats a write in the same cycle
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int s = 0; s < NSLOT; s++) begin
        cfg[s] <= ldg_cfg_rst(s);
      end
    end else begin
      for (int s = 0; s < NSLOT; s++) begin
        cfg[s] <= next_cfg[s];
      end
    end
  end

  // readback, one cycle behind the addressed register
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cfg_rdata <= 8'h00;
    end else begin
      o_cfg_rdata <= next_cfg_rdata;
    end
  end

  // host irq and dma lines
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq <= '0;
      o_drq <= '0;
    end else begin
      o_irq <= next_irq;
      o_drq <= next_drq;
    end
  end

  // io decode result, valid for one cycle per strobe cycle
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_dev_sel    <= '0;
      o_reg_off    <= 3'h0;
      o_pp_ext_sel <= 1'b0;
    end else begin
      o_dev_sel    <= next_dev_sel;
      o_reg_off    <= next_reg_off;
      o_pp_ext_sel <= next_pp_ext_sel;
    end
  end

endmodule

`default_nettype wire

/* core/ldg_pkg.sv */
// constants, field positions and carrier types for the logical device
// irq/dma gating block; shared by design and bench
package ldg_pkg;

  // device slots inside the block
  localparam int NSLOT     = 5;
  localparam int SLOT_FDC  = 0;
  localparam int SLOT_PP   = 1;
  localparam int SLOT_SA   = 2;
  localparam int SLOT_SB   = 3;
  localparam int SLOT_KBD  = 4;
  localparam int NSER      = 2;
  localparam int NDRQ_SRC  = 2;
  localparam int NIRQ      = 16;
  localparam int NDMA      = 4;

  // logical device number of each slot, slot 0 in the low bits
  localparam logic [14:0] LD_MAP0 = {3'h6, 3'h3, 3'h2, 3'h1, 3'h0};
  localparam logic [14:0] LD_MAP1 = {3'h7, 3'h4, 3'h2, 3'h3, 3'h0};

  // configuration register indexes
  localparam logic [7:0] IDX_BASE_HI = 8'h60;
  localparam logic [7:0] IDX_BASE_LO = 8'h61;
  localparam logic [7:0] IDX_IRQ_SEL = 8'h70;
  localparam logic [7:0] IDX_DMA_SEL = 8'h74;

  // reset values
  localparam logic [15:0] BASE_RST      = 16'h0000;
  localparam logic [3:0]  IRQ_RST_FDC   = 4'h6;
  localparam logic [3:0]  IRQ_RST_OTHER = 4'h0;
  localparam logic [2:0]  DMA_RST_FDC   = 3'h2;
  localparam logic [2:0]  DMA_RST_PP    = 3'h4;
  localparam logic [2:0]  DMA_RST_NONE  = 3'h0;

  // select encodings
  localparam logic [3:0] IRQ_SEL_NONE = 4'h0;
  localparam logic [2:0] DMA_CH_MIN   = 3'h1;
  localparam logic [2:0] DMA_CH_MAX   = 3'h3;

  // address windows
  localparam logic [11:0] BASE_MIN  = 12'h100;
  localparam logic [11:0] BASE_MAX8 = 12'hFF8;
  localparam logic [11:0] BASE_MAX4 = 12'hFFC;
  localparam logic [11:0] KBD_DATA  = 12'h060;
  localparam logic [11:0] KBD_CMD   = 12'h064;
  localparam logic [12:0] PP_EXT_LO = 13'h0400;
  localparam logic [12:0] PP_EXT_HI = 13'h0402;

  // bit positions in unit registers
  localparam int GLOBAL_CONFIG_REG_24H_QUAL16_BIT = 6;
  localparam int DOR_DMA_BIT     = 3;
  localparam int PCTL_PARALLEL_IRQ_ENABLE_BIT   = 4;
  localparam int ECR_SVC_BIT     = 2;
  localparam int ECR_DMA_BIT     = 3;
  localparam int ECR_MODE_LSB    = 5;
  localparam int IER_MSB         = 3;
  localparam int MCR_MODEM_AUX_OUTPUT_TWO_BIT    = 2;

  // parallel modes whose interrupt ignores the irq enable bit
  localparam logic [2:0] PMODE_FIFO = 3'b010;
  localparam logic [2:0] PMODE_ECP  = 3'b011;
  localparam logic [2:0] PMODE_TEST = 3'b110;

  typedef struct packed {
    logic [15:0] base;
    logic [3:0]  irq_sel;
    logic [2:0]  dma_sel;
  } ldg_ldcfg_type;

  function automatic ldg_ldcfg_type ldg_cfg_rst(input int s);
    ldg_ldcfg_type r;
    r.base    = BASE_RST;
    r.irq_sel = (s == SLOT_FDC) ? IRQ_RST_FDC : IRQ_RST_OTHER;
    r.dma_sel = (s == SLOT_FDC) ? DMA_RST_FDC :
                (s == SLOT_PP)  ? DMA_RST_PP  : DMA_RST_NONE;
    return r;
  endfunction

endpackage

/* bench/ldg_checker.sv */
// assertion checker for the irq/dma gating block, bound to its top module
// assumes one clock i_mclk and asynchronous active low i_nrst
`timescale 1ns/10ps
`default_nettype none
module ldg_checker
  import ldg_pkg::*;
(
  // clock and reset
  input wire logic                 i_mclk,
  input wire logic                 i_nrst,
  // watched inputs
  input wire logic [NSLOT-1:0]     i_dev_irq,
  input wire logic [NDRQ_SRC-1:0]  i_dev_drq,
  input wire logic [7:0]           i_floppy_digital_output_reg,
  input wire logic                 i_floppy_powered_down,
  input wire logic [NSER-1:0][7:0] i_modem_control_reg,
  input wire logic [7:0]           i_global_config_reg_24h,
  input wire logic [NSLOT-1:0]     i_dev_active,
  input wire logic [15:0]          i_io_addr,
  input wire logic                 i_io_strobe,
  // watched outputs
  input wire logic [NIRQ-1:0]      o_irq,
  input wire logic [NDMA-1:0]      o_drq,
  input wire logic [NSLOT-1:0]     o_dev_sel,
  input wire logic [2:0]           o_reg_off
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  line_zero_a: assert property (o_irq[0] == 1'b0 && o_drq[0] == 1'b0)
    else $error("line zero driven");
  irq_src_a: assert property (o_irq != '0 |-> $past(i_dev_irq) != '0)
    else $error("irq without source");
  drq_src_a: assert property (o_drq != '0 |-> $past(i_dev_drq) != '0)
    else $error("drq without source");
  fdc_gate_a: assert property (($past(i_dev_irq[4:1]) == 4'h0 && !$past(i_dev_drq[1]) &&
    (!$past(i_floppy_digital_output_reg[3]) || $past(i_floppy_powered_down)))
    |-> (o_irq == '0 && o_drq == '0)) else $error("floppy not gated");
  ser_gate_a: assert property (($past(i_dev_irq) == 5'h04 &&
    !$past(i_modem_control_reg[0][2])) |-> o_irq == '0) else $error("serial not gated");
  kbd_fixed_a: assert property (($past(i_io_strobe) && $past(i_io_addr) == 16'h0064 &&
    $past(i_dev_active[4])) |-> (o_dev_sel == 5'h10 && o_reg_off == 3'h4))
    else $error("keyboard decode wrong");
  qual_hi_a: assert property (($past(i_io_strobe) && $past(i_global_config_reg_24h[6]) &&
    $past(i_io_addr[15:12]) != 4'h0) |-> o_dev_sel == '0) else $error("upper address ignored");
  sel_idle_a: assert property (!$past(i_io_strobe) |-> o_dev_sel == '0)
    else $error("select without strobe");
  inactive_off_a: assert property ($past(i_dev_active) == '0 |->
    (o_dev_sel == '0 && o_irq == '0 && o_drq == '0)) else $error("inactive device drives");
  cover property (o_irq[6]);
  cover property (o_drq[3]);
  cover property (o_dev_sel == 5'h10);
endmodule
bind ldg_irq_dma_gate ldg_checker i_ldg_checker (.i_mclk, .i_nrst, .i_dev_irq, .i_dev_drq,
  .i_floppy_digital_output_reg, .i_floppy_powered_down, .i_modem_control_reg,
  .i_global_config_reg_24h, .i_dev_active, .i_io_addr, .i_io_strobe, .o_irq, .o_drq,
  .o_dev_sel, .o_reg_off);
`default_nettype wire

/* bench/ldg_host_model.sv */
// host side model: latches rising edges of the edge high request lines
// assumes the lines come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module ldg_host_model (
  // clock, reset and clear
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic        i_clear,
  // device lines
  input  wire logic [15:0] i_irq,
  // what the host has seen
  output logic      [15:0] o_irq_seen
);
  logic [15:0] irq_last;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_last <= '0;
      o_irq_seen <= '0;
    end else begin
      irq_last <= i_irq;
      o_irq_seen <= i_clear ? '0 : (o_irq_seen | (i_irq & ~irq_last));
    end
  end
endmodule
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the irq/dma gating block
// assumes the checker is bound from its own file
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ldg_pkg::*;
  logic i_mclk = 0, i_nrst = 0, i_soft_rst = 0, i_cfg_wr = 0, i_floppy_powered_down = 0;
  logic i_pp_ecp_mode = 0, i_kbd_irq_enable = 1, i_io_strobe = 0, i_device_numbering_select = 0;
  logic [2:0] i_cfg_ld = '0;
  logic [7:0] i_cfg_index = '0, i_cfg_wdata = '0, i_global_config_reg_24h = '0;
  logic [7:0] i_floppy_digital_output_reg = '0, i_parallel_control_reg = '0;
  logic [7:0] i_ecp_ext_control_reg = '0, o_cfg_rdata;
  logic [NSER-1:0][7:0] i_uart_int_enable_reg = '0, i_modem_control_reg = '0;
  logic [NSLOT-1:0] i_dev_active = '0, i_dev_irq = '0, o_dev_sel;
  logic [NDRQ_SRC-1:0] i_dev_drq = '0;
  logic [15:0] i_io_addr = '0, o_irq, seen;
  logic [NDMA-1:0] o_drq;
  logic [2:0] o_reg_off;
  logic o_pp_ext_sel, clr = 0;
  int n_fail = 0, n_compared = 0, cyc = 0;
  always #25 i_mclk = ~i_mclk;
  ldg_irq_dma_gate i_ldg_irq_dma_gate (.*);
  ldg_host_model i_ldg_host_model (.i_mclk, .i_nrst, .i_clear(clr), .i_irq(o_irq),
    .o_irq_seen(seen));
  task automatic stop_test();
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #5;
  endtask
  task automatic wr(input logic [2:0] ld, input logic [7:0] idx, d);
    step(1);
    {i_cfg_wr, i_cfg_ld, i_cfg_index, i_cfg_wdata} = {1'b1, ld, idx, d};
    step(1);
    i_cfg_wr = 0;
  endtask
  task automatic rd(input logic [2:0] ld, input logic [7:0] idx, exp);
    {i_cfg_ld, i_cfg_index} = {ld, idx};
    step(2);
    chk({8'h00, o_cfg_rdata}, {8'h00, exp});
  endtask
  task automatic base(input logic [2:0] ld, input logic [15:0] b);
    wr(ld, IDX_BASE_HI, b[15:8]);
    wr(ld, IDX_BASE_LO, b[7:0]);
  endtask
  task automatic ci(input logic [15:0] exp);
    step(2);
    chk(o_irq, exp);
  endtask
  task automatic cd(input logic [3:0] exp);
    step(2);
    chk({12'h000, o_drq}, {12'h000, exp});
  endtask
  task automatic io(input logic [15:0] a, input logic [4:0] s, input logic [2:0] o, input e);
    {i_io_addr, i_io_strobe} = {a, 1'b1};
    step(1);
    chk({7'h00, o_pp_ext_sel, o_dev_sel, o_reg_off}, {7'h00, e, s, o});
    i_io_strobe = 0;
    step(1);
  endtask
  task automatic t_reset();
    rd(0, 8'h70, 8'h06);
    rd(0, 8'h74, 8'h02);
    rd(1, 8'h74, 8'h04);
    rd(2, 8'h70, 8'h00);
    i_device_numbering_select = 1;
    rd(3, 8'h74, 8'h04);
    i_device_numbering_select = 0;
    wr(0, 8'h70, 8'h03);
    rd(0, 8'h70, 8'h03);
    i_soft_rst = 1;
    rd(0, 8'h70, 8'h06);
    i_soft_rst = 0;
  endtask
  task automatic t_fdc();
    i_dev_active = 5'h1F;
    base(0, 16'h03F0);
    {i_dev_irq, i_floppy_digital_output_reg, i_dev_drq} = {5'h01, 8'h08, 2'b01};
    ci(16'h0040);
    chk(seen, 16'h0040);
    cd(4'h4);
    for (int d = 0; d < 8; d++) begin
      wr(0, IDX_DMA_SEL, 8'(d));
      cd((d inside {[1:3]}) ? 4'(1 << d) : 4'h0);
    end
    wr(0, IDX_DMA_SEL, 8'h02);
    i_floppy_digital_output_reg = 0;
    ci(16'h0000);
    cd(4'h0);
    {i_floppy_digital_output_reg, i_floppy_powered_down} = {8'h08, 1'b1};
    ci(16'h0000);
    cd(4'h0);
    i_floppy_powered_down = 0;
    wr(0, IDX_IRQ_SEL, 8'h00);
    ci(16'h0000);
    {i_dev_irq, i_dev_drq} = '0;
  endtask
  task automatic t_serial();
    base(2, 16'h03F8);
    base(3, 16'h02F8);
    wr(2, IDX_IRQ_SEL, 8'h04);
    wr(3, IDX_IRQ_SEL, 8'h04);
    {i_dev_irq, i_modem_control_reg} = {5'h04, 16'h0004};
    ci(16'h0000);
    i_uart_int_enable_reg = 16'h0801;
    ci(16'h0010);
    i_modem_control_reg = 0;
    ci(16'h0000);
    {i_dev_irq, i_modem_control_reg} = {5'h0C, 16'h0400};
    ci(16'h0010);
    i_dev_active[3] = 0;
    ci(16'h0000);
    {i_dev_active, i_dev_irq} = {5'h1F, 5'h00};
  endtask
  task automatic t_par();
    base(1, 16'h0378);
    wr(1, IDX_IRQ_SEL, 8'h07);
    wr(1, IDX_DMA_SEL, 8'h03);
    {i_dev_irq, i_parallel_control_reg} = {5'h02, 8'h10};
    ci(16'h0080);
    i_parallel_control_reg = 0;
    ci(16'h0000);
    i_pp_ecp_mode = 1;
    for (int m = 0; m < 8; m++) begin
      i_ecp_ext_control_reg = {3'(m), 5'h00};
      ci((m == 2 || m == 3 || m == 6) ? 16'h0080 : 16'h0000);
    end
    i_ecp_ext_control_reg = 8'h64;
    ci(16'h0000);
    {i_dev_drq, i_ecp_ext_control_reg} = {2'b10, 8'h68};
    cd(4'h8);
    i_ecp_ext_control_reg = 8'h60;
    cd(4'h0);
    {i_dev_irq, i_dev_drq, i_pp_ecp_mode} = '0;
  endtask
  task automatic t_decode();
    io(16'h03F2, 5'h01, 3'h2, 0);
    io(16'h03F7, 5'h01, 3'h7, 0);
    io(16'h077A, 5'h02, 3'h2, 1);
    io(16'h0064, 5'h10, 3'h4, 0);
    io(16'h0060, 5'h10, 3'h0, 0);
    io(16'h13F2, 5'h01, 3'h2, 0);
    i_global_config_reg_24h = 8'h40;
    io(16'h13F2, 5'h00, 3'h0, 0);
    base(0, 16'h03F4);
    io(16'h03F4, 5'h00, 3'h0, 0);
  endtask
  initial begin
    step(16);
    i_nrst = 1;
    t_reset();
    t_fdc();
    t_serial();
    t_par();
    t_decode();
    stop_test();
  end
endmodule
`default_nettype wire
